// ### inc/line_driver_pkg.sv
// Shared constants and types for the line driver mode decoder
// Functional notes
// - Mode lives in config bits 7:5, read/write
// - Code 000: switches and receiver off
// - Code 001: low switch on when data and enable
// - Code 010: high switch on when data low, enable
// - Push-pull: data low high switch, high low switch
// - Push-pull with enable low: both switches off
// - Push-pull: dead interval between opposite switch turn-ons
// - Code 100 default: switches off, receiver still on
// - Enable high: receive high; else inverted line level
// - Code 101: low switch permanently on
// - Code 110: high switch permanently on
// - Any register access releases latched overload shutdown
// - Active-to-active change refused, old mode kept, parity error
package line_driver_pkg;

  // Output stage operating modes, coded as in the mode field
  typedef enum logic [2:0] {
    MODE_OFF      = 3'h0,
    MODE_LOW      = 3'h1,
    MODE_HIGH     = 3'h2,
    MODE_PP       = 3'h3,
    MODE_TRI      = 3'h4,
    MODE_LOW_ON   = 3'h5,
    MODE_HIGH_ON  = 3'h6,
    MODE_PP_IND   = 3'h7
  } mode_type;

  // Field position of the mode inside the configuration register
  localparam int        MODE_MSB   = 7;
  localparam int        MODE_LSB   = 5;
  localparam mode_type  MODE_RESET = MODE_TRI;

  // Clock and dead interval timing
  localparam int        CLK_NS       = 100;
  localparam int        DEAD_TIME_NS = 500;
  // Least time, so round up to whole cycles, never below one
  localparam int        DEAD_CYC_RAW = (DEAD_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int        DEAD_CYC     = (DEAD_CYC_RAW < 1) ? 1 : DEAD_CYC_RAW;
  localparam int        DEAD_W       = 4;

endpackage

// ### design/switch_dead_gate.sv
// Switch command stage with dead interval between opposite switches
`timescale 1ns/1ps
module switch_dead_gate
  import line_driver_pkg::*;
#(
  parameter int unsigned DEAD = DEAD_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic want_high,
  input  wire logic want_low,
  input  wire logic dead_en,
  output logic      high_on,
  output logic      low_on
);

  logic [DEAD_W-1:0] dead_cnt_ff;   // Cycles left in the dead interval
  logic              high_off_now;  // High switch is being released
  logic              low_off_now;   // Low switch is being released
  logic              dead_busy;     // Dead interval still running
  logic              high_ff;       // Registered high switch command
  logic              low_ff;        // Registered low switch command

  assign high_off_now = high_ff && !want_high;
  assign low_off_now  = low_ff && !want_low;
  assign dead_busy    = dead_en && (dead_cnt_ff != '0);
  assign high_on      = high_ff;
  assign low_on       = low_ff;

  // Dead interval counter, restarted by every turn-off while dead_en is set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dead_cnt_ff <= '0;
    end else if ((high_off_now || low_off_now) && dead_en) begin
      dead_cnt_ff <= DEAD_W'(DEAD);
    end else if (dead_cnt_ff != '0) begin
      dead_cnt_ff <= dead_cnt_ff - 1'b1;
    end
  end

  // Switch commands: turn-off at once, turn-on only when safe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_ff <= 1'b0;
      low_ff  <= 1'b0;
    end else begin
      // Off requests never wait, so a fault or mode change is fast
      if (high_off_now) begin
        high_ff <= 1'b0;
      end else if (want_high && !low_ff && !dead_busy) begin
        high_ff <= 1'b1;
      end
      if (low_off_now) begin
        low_ff <= 1'b0;
      end else if (want_low && !high_ff && !dead_busy) begin
        low_ff <= 1'b1;
      end
    end
  end

endmodule

// ### design/line_driver_mode_decoder.sv
// Output stage mode decoder for a three-wire industrial line port
`timescale 1ns/1ps
module line_driver_mode_decoder
  import line_driver_pkg::*;
#(
  parameter int unsigned DEAD = DEAD_CYC
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  // Host drive enable, transmit data and sensed line (pins)
  input  wire logic       DRIVE_EN,
  input  wire logic       TX_DATA,
  input  wire logic       LINE_SENSE,
  // Register access from the serial front end, same clock
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic       CFG_SEL,
  input  wire logic [7:0] REG_WDATA,
  // Overload protection interface
  input  wire logic       LATCH_MODE,
  input  wire logic       CUTOFF_EVT,
  // Results
  output logic [7:0]      CFG_RDATA,
  output logic            PARITY_ERR,
  output logic            SHUTDOWN,
  output logic            RX_OUT,
  output logic            HIGH_SWITCH,
  output logic            LOW_SWITCH
);

  // Pin synchronisers; stage one is read only by stage two
  logic       en_s1_ff;         // Drive enable, first stage
  logic       en_s2_ff;         // Drive enable, usable
  logic       tx_s1_ff;         // Transmit data, first stage
  logic       tx_s2_ff;         // Transmit data, usable
  logic       line_s1_ff;       // Line level, first stage
  logic       line_s2_ff;       // Line level, usable
  logic       cut_s1_ff;        // Cut-off event, first stage
  logic       cut_s2_ff;        // Cut-off event, usable

  mode_type   mode_ff;          // Current output stage mode
  mode_type   nxt_mode;         // Mode requested by a write
  logic       mode_refuse;      // Write asks a forbidden jump
  logic       pe_ff;            // Parity error pulse register
  logic [7:0] rdata_ff;         // Configuration read-back
  logic       shut_ff;          // Latched overload shutdown
  logic       rx_ff;            // Receive output register
  logic       want_high;        // Decoded high switch request
  logic       want_low;         // Decoded low switch request
  logic       dead_en;          // Dead interval active in this mode

  // Two-flop synchronisers for all asynchronous pin inputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      en_s1_ff   <= 1'b0;
      en_s2_ff   <= 1'b0;
      tx_s1_ff   <= 1'b0;
      tx_s2_ff   <= 1'b0;
      line_s1_ff <= 1'b0;
      line_s2_ff <= 1'b0;
      cut_s1_ff  <= 1'b0;
      cut_s2_ff  <= 1'b0;
    end else begin
      en_s1_ff   <= DRIVE_EN;
      en_s2_ff   <= en_s1_ff;
      tx_s1_ff   <= TX_DATA;
      tx_s2_ff   <= tx_s1_ff;
      line_s1_ff <= LINE_SENSE;
      line_s2_ff <= line_s1_ff;
      cut_s1_ff  <= CUTOFF_EVT;
      cut_s2_ff  <= cut_s1_ff;
    end
  end

  // Active modes drive the line; off and tri-state do not
  function automatic logic is_active(input mode_type m);
    is_active = (m != MODE_OFF) && (m != MODE_TRI);
  endfunction

  // Decode the requested mode and check the jump
  always_comb begin
    nxt_mode    = mode_type'(REG_WDATA[MODE_MSB:MODE_LSB]);
    // Rewriting the same active mode is harmless and allowed
    mode_refuse = is_active(mode_ff) && is_active(nxt_mode)
                  && (nxt_mode != mode_ff);
  end

  // Mode register: a refused write leaves the old mode in place
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_ff <= MODE_RESET;
    end else if (REG_WR && CFG_SEL && !mode_refuse) begin
      mode_ff <= nxt_mode;
    end
  end

  // Parity error reported for one cycle on a refused jump
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pe_ff <= 1'b0;
    end else begin
      pe_ff <= REG_WR && CFG_SEL && mode_refuse;
    end
  end

  // Read-back: mode in the top bits, unused bits read as zero
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= {mode_ff, 5'h00};
    end
  end

  // Latched shutdown; a new cut-off wins over a releasing access
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shut_ff <= 1'b0;
    end else if (LATCH_MODE && cut_s2_ff) begin
      shut_ff <= 1'b1;
    end else if (REG_WR || REG_RD) begin
      shut_ff <= 1'b0;
    end else if (!LATCH_MODE) begin
      // Outside latched mode the protection restarts on its own
      shut_ff <= 1'b0;
    end
  end

  // Switch request decoder, one case per mode except the two push-pull modes, which share one
  always_comb begin
    want_high = 1'b0;
    want_low  = 1'b0;
    dead_en   = 1'b0;
    case (mode_ff)
      MODE_OFF: begin
        // Nothing driven, inputs ignored
        want_high = 1'b0;
      end
      MODE_LOW: begin
        want_low = tx_s2_ff && en_s2_ff;
      end
      MODE_HIGH: begin
        // Host should have turned the pull-down off first
        want_high = !tx_s2_ff && en_s2_ff;
      end
      MODE_PP, MODE_PP_IND: begin
        dead_en   = 1'b1;
        want_high = en_s2_ff && !tx_s2_ff;
        want_low  = en_s2_ff && tx_s2_ff;
      end
      MODE_TRI: begin
        want_low = 1'b0;
      end
      MODE_LOW_ON: begin
        want_low = 1'b1;
      end
      MODE_HIGH_ON: begin
        want_high = 1'b1;
      end
      default: begin
        want_high = 1'b0;
      end
    endcase
    // Overload shutdown overrides every mode
    if (shut_ff) begin
      want_high = 1'b0;
      want_low  = 1'b0;
    end
  end

  // Receive output: high while driving or while receiver is off
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_ff <= 1'b1;
    end else if (mode_ff == MODE_OFF) begin
      rx_ff <= 1'b1;
    end else if (en_s2_ff) begin
      rx_ff <= 1'b1;
    end else begin
      rx_ff <= !line_s2_ff;
    end
  end

  // Switch stage with turn-on guard and dead interval
  switch_dead_gate #(
    .DEAD      (DEAD)
  ) u_gate (
    .clk       (CLK),
    .rst       (RST),
    .want_high (want_high),
    .want_low  (want_low),
    .dead_en   (dead_en),
    .high_on   (HIGH_SWITCH),
    .low_on    (LOW_SWITCH)
  );

  assign CFG_RDATA  = rdata_ff;
  assign PARITY_ERR = pe_ff;
  assign SHUTDOWN   = shut_ff;
  assign RX_OUT     = rx_ff;

endmodule

// ### sim/line_partner.sv
// Far-side line model driven by the two switches
`timescale 1ns/1ps
module line_partner (
  input  wire logic high_on,
  input  wire logic low_on,
  input  wire logic pull_lvl,
  output logic      sense
);
  // Released line rests at the pull level the host picked
  assign sense = high_on ? 1'h1 : (low_on ? 1'h0 : pull_lvl);
endmodule

// ### sim/line_driver_assertions.sv
// Port checker for the line driver mode decoder
`timescale 1ns/1ps
module line_driver_checker
  import line_driver_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic       DRIVE_EN,
  input wire logic       TX_DATA,
  input wire logic       LINE_SENSE,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic       CFG_SEL,
  input wire logic [7:0] REG_WDATA,
  input wire logic       LATCH_MODE,
  input wire logic       CUTOFF_EVT,
  input wire logic [7:0] CFG_RDATA,
  input wire logic       PARITY_ERR,
  input wire logic       SHUTDOWN,
  input wire logic       RX_OUT,
  input wire logic       HIGH_SWITCH,
  input wire logic       LOW_SWITCH
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Low switch stays off for two cycles after the high switch falls
  sequence lo_gap_s; !LOW_SWITCH [*2]; endsequence
  AST_LOW_BITS: assert property (CFG_RDATA[4:0] == 5'h00)
    else $error("config low bits not zero");
  AST_NO_OVERLAP: assert property (!(HIGH_SWITCH && LOW_SWITCH))
    else $error("both switches on");
  AST_DEAD_GAP: assert property ($fell(HIGH_SWITCH) |-> lo_gap_s)
    else $error("no dead interval before low switch");
  AST_IDLE: assert property ((CFG_RDATA[6:5] == 2'h0) [*4]
    |-> !HIGH_SWITCH && !LOW_SWITCH) else $error("switch on in idle");
  AST_LOW_ON: assert property ((CFG_RDATA[7:5] == 3'h5 && !SHUTDOWN) [*5]
    |-> LOW_SWITCH) else $error("low switch not held on");
  AST_HIGH_ON: assert property ((CFG_RDATA[7:5] == 3'h6 && !SHUTDOWN) [*5]
    |-> HIGH_SWITCH) else $error("high switch not held on");
  AST_RX_DRIVE: assert property (DRIVE_EN [*4] |-> RX_OUT)
    else $error("receive low while driving");
  AST_RX_LINE: assert property ((!DRIVE_EN && $stable(LINE_SENSE) &&
    CFG_RDATA[7:5] != 3'h0) [*5] |-> RX_OUT == !LINE_SENSE)
    else $error("receive not inverse of line");
  AST_PAR_CAUSE: assert property (PARITY_ERR |->
    $past(REG_WR && CFG_SEL && REG_WDATA[6:5] != 2'h0))
    else $error("parity error without active write");
  AST_PAR_KEEP: assert property (PARITY_ERR && !REG_WR
    |=> $stable(CFG_RDATA)) else $error("refused mode was taken");
endmodule
bind line_driver_mode_decoder line_driver_checker chk (.*);

// ### sim/line_driver_mode_decoder_bench.sv
// Self-checking bench for the line driver mode decoder
`timescale 1ns/1ps
module line_driver_mode_decoder_bench;
  import line_driver_pkg::*;
  logic       CLK = 1'h0;   // 100 ns clock
  logic       RST = 1'h1;   // Held for 20 cycles
  logic       DRIVE_EN, TX_DATA, LINE_SENSE, REG_WR, REG_RD, CFG_SEL;
  logic       LATCH_MODE, CUTOFF_EVT, PULL;
  logic [7:0] REG_WDATA, CFG_RDATA;
  logic       PARITY_ERR, SHUTDOWN, RX_OUT, HIGH_SWITCH, LOW_SWITCH;
  int         error_cnt, cmp_count, cycles;
  // Rows: mode, enable, data, pull, high, low, receive
  logic [8:0] rows [17] = '{9'h019, 9'h073, 9'h061, 9'h058, 9'h0a5,
    9'h0b1, 9'h0e5, 9'h0f3, 9'h0d1, 9'h1e5, 9'h1f3, 9'h1c8, 9'h121,
    9'h108, 9'h143, 9'h1b5, 9'h184};
  // Short dead interval keeps reversal checks brief
  line_driver_mode_decoder #(.DEAD(1)) DUT (.*);
  line_partner partner (.high_on(HIGH_SWITCH), .low_on(LOW_SWITCH),
    .pull_lvl(PULL), .sense(LINE_SENSE));
  always #50 CLK = ~CLK;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // One-cycle write strobe; an idle cycle always precedes it
  task automatic wr(input logic [7:0] d);
    @(posedge CLK);
    REG_WR    <= 1'h1;
    CFG_SEL   <= 1'h1;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'h0;
  endtask
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard, well above the roughly 275 cycles needed
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    {DRIVE_EN, TX_DATA, REG_WR, REG_RD, CFG_SEL} = 5'h00;
    {LATCH_MODE, CUTOFF_EVT, PULL} = 3'h0;
    REG_WDATA = 8'h00;
    cyc(20);
    RST <= 1'h0;
    @(negedge CLK);
    chk({5'h00, HIGH_SWITCH, LOW_SWITCH, RX_OUT}, 8'h01);
    cyc(2);
    @(negedge CLK);
    chk(CFG_RDATA, 8'h80);
    // Each row passes through off, so no jump is refused
    foreach (rows[i]) begin
      wr(8'h00);
      wr({rows[i][8:6], 5'h1f});
      DRIVE_EN <= rows[i][5];
      TX_DATA  <= rows[i][4];
      PULL     <= rows[i][3];
      cyc(8);
      @(negedge CLK);
      chk(CFG_RDATA, {rows[i][8:6], 5'h00});
      chk({5'h00, HIGH_SWITCH, LOW_SWITCH, RX_OUT},
        {5'h00, rows[i][2:0]});
    end
    // Direct jump push-pull to high-side is refused
    wr(8'h00);
    wr(8'h60);
    wr(8'h40);
    @(negedge CLK);
    chk({7'h00, PARITY_ERR}, 8'h01);
    cyc(2);
    @(negedge CLK);
    chk(CFG_RDATA, 8'h60);
    wr(8'h60);
    @(negedge CLK);
    chk({7'h00, PARITY_ERR}, 8'h00);
    // Reversal high to low must show two quiet cycles
    cyc(1);
    DRIVE_EN <= 1'h1;
    TX_DATA  <= 1'h0;
    cyc(8);
    TX_DATA <= 1'h1;
    for (int k = 0; k < 8 && HIGH_SWITCH === 1'h1; k++) @(negedge CLK);
    chk({6'h00, HIGH_SWITCH, LOW_SWITCH}, 8'h00);
    @(negedge CLK);
    chk({6'h00, HIGH_SWITCH, LOW_SWITCH}, 8'h00);
    repeat (3) @(negedge CLK);
    chk({6'h00, HIGH_SWITCH, LOW_SWITCH}, 8'h01);
    // Latched overload holds until a register access
    cyc(1);
    LATCH_MODE <= 1'h1;
    CUTOFF_EVT <= 1'h1;
    cyc(1);
    CUTOFF_EVT <= 1'h0;
    cyc(12);
    @(negedge CLK);
    chk({5'h00, SHUTDOWN, HIGH_SWITCH, LOW_SWITCH}, 8'h04);
    cyc(1);
    REG_RD <= 1'h1;
    cyc(1);
    REG_RD <= 1'h0;
    cyc(6);
    @(negedge CLK);
    chk({5'h00, SHUTDOWN, HIGH_SWITCH, LOW_SWITCH}, 8'h01);
    tally_and_finish();
  end
endmodule
